//--- include/csif_pkg.sv
// constants and types shared by the codec status and interrupt flag block
package csif_pkg;

  // register addresses on the control port (byte address space)
  localparam logic [7:0] MASK1_ADDR        = 8'h5e;
  localparam logic [7:0] MASK2_ADDR        = 8'h5f;
  localparam logic [7:0] FAULT_STATUS_ADDR = 8'h60;
  localparam logic [7:0] LOCK_STATUS_ADDR  = 8'h61;

  // fault_event_status field positions
  localparam int IP_A_CLIP_BIT  = 0;
  localparam int IP_B_CLIP_BIT  = 1;
  localparam int MIX_CLIP_BIT   = 3;
  localparam int OVERTEMP_BIT   = 4;
  localparam int MIC_SHORT_BIT  = 6;
  localparam logic [7:0] FAULT_USED_BITS = 8'h5b;

  // converter_lock_status field positions
  localparam int AUX_IN_LOCK_BIT    = 0;
  localparam int AUX_OUT_LOCK_BIT   = 1;
  localparam int MUSIC_IN_LOCK_BIT  = 2;
  localparam int MUSIC_OUT_LOCK_BIT = 3;
  localparam int VOICE_IN_LOCK_BIT  = 4;
  localparam int VOICE_OUT_LOCK_BIT = 5;
  localparam int NUM_LOCKS          = 6;
  localparam logic [7:0] LOCK_USED_BITS = 8'h3f;

  // reset values
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // timing
  localparam int REF_CLK_HZ         = 200_000_000;
  localparam int MIC_DEBOUNCE_MS    = 20;
  localparam int MIC_DEBOUNCE_CYCLES = REF_CLK_HZ / 1000 * MIC_DEBOUNCE_MS;
  localparam int LOCK_TIME_PROG_MS  = 19;
  localparam int LOCK_TIME_CTP_8K_MS = 93;
  localparam int LOCK_TIME_CTP_48K_MS = 11;
  localparam int LOCK_TIME_PTC_8K_MS = 63;
  localparam int LOCK_TIME_PTC_48K_MS = 43;
  localparam int LOCK_TIMER_W       = 32;

  // control port access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csif_req_t;

  // condition inputs from the codec core
  typedef struct packed {
    logic [1:0] input_path_clip;
    logic       mixer_clip;
    logic       overtemp;
    logic       thermal_sense_en;
    logic       mic_short_raw;
    logic       mic_bias_powerdown;
    logic       global_powerdown;
  } csif_cond_t;

  typedef enum logic [1:0] {
    CSIF_DB_IDLE,
    CSIF_DB_COUNT
  } csif_db_state_t;

endpackage

//--- rtl/csif_status_irq.sv
// status flags, masks and interrupt output of the codec core
//
// Function
// - mic short flag is live: reads 1 while short present, 0 otherwise
// - mic short events posted only with mic bias and global power up
// - overtemp flag latches high when sensing enabled and threshold exceeded
// - latched flag rising edge requests interrupt only when its mask unmasks
// - mixer clip flag latches 1 on any digital mixer clipping
// - one latching clip flag per input path channel
// - lock status: voice out 5, voice in 4, music 3/2, aux 1/0
// - six converter lock flags latch high, rising edge is interrupt source
// - lock time measured; expected within 19 ms when rate programmed
// - mask bit 1 unmasks, 0 masks; masks reset to zero
// - mic short debounced 20 ms both edges; either edge can interrupt
`timescale 1ns/1ps
`default_nettype none
module csif_status_irq (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire csif_pkg::csif_req_t    host_req,
  input  wire csif_pkg::csif_cond_t   cond,
  input  wire logic [5:0]             lock_raw,
  input  wire logic [5:0]             rate_programmed,
  output logic [7:0]                  rdata,
  output logic                        rdata_valid,
  output logic                        irq,
  output logic [31:0]                 last_lock_cycles
);

  // two-flop synchronisers for condition levels from other domains
  logic [11:0] sync1_q;
  logic [11:0] sync2_q;
  logic [11:0] async_in;

  assign async_in = {lock_raw, cond.input_path_clip, cond.mixer_clip, cond.overtemp,
                     cond.mic_short_raw, cond.thermal_sense_en};

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_q <= 12'h000;
      sync2_q <= 12'h000;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  logic [5:0] lock_s;
  logic [1:0] ip_clip_s;
  logic       mix_clip_s;
  logic       overtemp_s;
  logic       mic_raw_s;
  logic       therm_en_s;

  assign lock_s     = sync2_q[11:6];
  assign ip_clip_s  = sync2_q[5:4];
  assign mix_clip_s = sync2_q[3];
  assign overtemp_s = sync2_q[2];
  assign mic_raw_s  = sync2_q[1];
  assign therm_en_s = sync2_q[0];

  // power-down bits are register outputs on the same clock, no sync needed
  logic mic_bias_up;
  assign mic_bias_up = !cond.mic_bias_powerdown && !cond.global_powerdown;

  // mic short debounce: new level must hold for the full interval
  logic [31:0]                  db_cnt_q;
  logic                         mic_short_flag_q;
  csif_pkg::csif_db_state_t     db_state_q;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      db_state_q       <= csif_pkg::CSIF_DB_IDLE;
      db_cnt_q         <= 32'h0000_0000;
      mic_short_flag_q <= 1'b0;
    end
    else if (!mic_bias_up)
    begin
      // bias off: short sensing is meaningless, flag forced low
      db_state_q       <= csif_pkg::CSIF_DB_IDLE;
      db_cnt_q         <= 32'h0000_0000;
      mic_short_flag_q <= 1'b0;
    end
    else
    begin
      case (db_state_q)
        csif_pkg::CSIF_DB_IDLE:
        begin
          db_cnt_q <= 32'h0000_0000;
          if (mic_raw_s != mic_short_flag_q)
          begin
            db_state_q <= csif_pkg::CSIF_DB_COUNT;
          end
        end
        csif_pkg::CSIF_DB_COUNT:
        begin
          if (mic_raw_s == mic_short_flag_q)
          begin
            db_state_q <= csif_pkg::CSIF_DB_IDLE;
          end
          else if (db_cnt_q == 32'(csif_pkg::MIC_DEBOUNCE_CYCLES - 2))
          begin
            mic_short_flag_q <= mic_raw_s;
            db_state_q       <= csif_pkg::CSIF_DB_IDLE;
          end
          else
          begin
            db_cnt_q <= db_cnt_q + 32'h0000_0001;
          end
        end
        default:
        begin
          db_state_q <= csif_pkg::CSIF_DB_IDLE;
        end
      endcase
    end
  end

  // masks
  logic [7:0] mask1_q;
  logic [7:0] mask2_q;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mask1_q <= csif_pkg::MASK_RESET;
      mask2_q <= csif_pkg::MASK_RESET;
    end
    else if (host_req.wr)
    begin
      // reserved mask bits stay zero so they can never unmask a dead source
      if (host_req.addr == csif_pkg::MASK1_ADDR)
      begin
        mask1_q <= host_req.wdata & csif_pkg::FAULT_USED_BITS;
      end
      if (host_req.addr == csif_pkg::MASK2_ADDR)
      begin
        mask2_q <= host_req.wdata & csif_pkg::LOCK_USED_BITS;
      end
    end
  end

  // current condition vectors in register layout
  logic [7:0] fault_now;
  logic [7:0] lock_now;

  always_comb
  begin
    fault_now = 8'h00;
    fault_now[csif_pkg::IP_A_CLIP_BIT] = ip_clip_s[0];
    fault_now[csif_pkg::IP_B_CLIP_BIT] = ip_clip_s[1];
    fault_now[csif_pkg::MIX_CLIP_BIT]  = mix_clip_s;
    fault_now[csif_pkg::OVERTEMP_BIT]  = overtemp_s && therm_en_s;
    fault_now[csif_pkg::MIC_SHORT_BIT] = mic_short_flag_q;
    lock_now = {2'b00, lock_s};
  end

  // sticky latches; a read clears, but a same-cycle event still sets
  logic       rd_fault;
  logic       rd_lock;
  logic [7:0] fault_sticky_q;
  logic [7:0] lock_sticky_q;
  logic [7:0] fault_prev_q;
  logic [7:0] lock_prev_q;
  logic [7:0] fault_rise;
  logic [7:0] lock_rise;
  logic [7:0] fault_evt_q;
  logic [7:0] lock_evt_q;
  logic       mic_edge;

  assign rd_fault = host_req.rd && (host_req.addr == csif_pkg::FAULT_STATUS_ADDR);
  assign rd_lock  = host_req.rd && (host_req.addr == csif_pkg::LOCK_STATUS_ADDR);
  assign fault_rise = fault_now & ~fault_prev_q;
  assign lock_rise  = lock_now & ~lock_prev_q;
  assign mic_edge = fault_now[csif_pkg::MIC_SHORT_BIT] != fault_prev_q[csif_pkg::MIC_SHORT_BIT];

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fault_prev_q   <= csif_pkg::STATUS_RESET;
      lock_prev_q    <= csif_pkg::STATUS_RESET;
      fault_sticky_q <= csif_pkg::STATUS_RESET;
      lock_sticky_q  <= csif_pkg::STATUS_RESET;
    end
    else
    begin
      fault_prev_q <= fault_now;
      lock_prev_q  <= lock_now;
      // after a read the flag re-evaluates to the live condition
      fault_sticky_q <= (rd_fault ? 8'h00 : fault_sticky_q) | fault_now;
      lock_sticky_q  <= (rd_lock ? 8'h00 : lock_sticky_q) | lock_now;
    end
  end

  // pending interrupt events, one per status bit
  logic [7:0] fault_edges;
  always_comb
  begin
    fault_edges = fault_rise;
    // the drop forced by bias power-down is not a short event
    fault_edges[csif_pkg::MIC_SHORT_BIT] = mic_edge && mic_bias_up;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fault_evt_q <= 8'h00;
      lock_evt_q  <= 8'h00;
    end
    else
    begin
      fault_evt_q <= (rd_fault ? 8'h00 : fault_evt_q) | (fault_edges & mask1_q);
      lock_evt_q  <= (rd_lock ? 8'h00 : lock_evt_q) | (lock_rise & mask2_q);
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(fault_evt_q & mask1_q) || |(lock_evt_q & mask2_q);
    end
  end

  // read data: mic short bit is live, others sticky; reserved read zero
  logic [7:0] fault_view;
  always_comb
  begin
    fault_view = fault_sticky_q & csif_pkg::FAULT_USED_BITS;
    fault_view[csif_pkg::MIC_SHORT_BIT] = mic_short_flag_q;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= host_req.rd;
      if (host_req.rd)
      begin
        case (host_req.addr)
          csif_pkg::MASK1_ADDR:        rdata <= mask1_q;
          csif_pkg::MASK2_ADDR:        rdata <= mask2_q;
          csif_pkg::FAULT_STATUS_ADDR: rdata <= fault_view;
          csif_pkg::LOCK_STATUS_ADDR:  rdata <= lock_sticky_q & csif_pkg::LOCK_USED_BITS;
          default:                     rdata <= 8'h00;
        endcase
      end
    end
  end

  // lock timing: cycles from any converter leaving lock until all six are locked again
  // rate_programmed is not used anywhere; lock time is measured, not enforced
  logic [31:0] lock_timer_q;
  logic        timing_q;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      lock_timer_q     <= 32'h0000_0000;
      timing_q         <= 1'b0;
      last_lock_cycles <= 32'h0000_0000;
    end
    else if (!timing_q && (lock_now[5:0] != 6'h3f))
    begin
      // the first cycle without lock already counts
      timing_q     <= 1'b1;
      lock_timer_q <= 32'h0000_0001;
    end
    else if (timing_q && (lock_now[5:0] == 6'h3f))
    begin
      timing_q         <= 1'b0;
      last_lock_cycles <= lock_timer_q;
    end
    else if (timing_q && (lock_timer_q != 32'hffff_ffff))
    begin
      lock_timer_q <= lock_timer_q + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

//--- bench/csif_status_irq_assertions.sv
// port checker for the status and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module csif_status_irq_chk (
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire csif_pkg::csif_req_t  host_req,
  input wire csif_pkg::csif_cond_t cond,
  input wire logic [5:0]           lock_raw,
  input wire logic [7:0]           rdata,
  input wire logic                 rdata_valid,
  input wire logic                 irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence rd_at(logic [7:0] a);
    host_req.rd && host_req.addr == a;
  endsequence
  // inputs pass two sync flops and a flag stage first
  sequence locks_held;
    (lock_raw == 6'h3f) [*5];
  endsequence
  read_answer_a: assert property (host_req.rd |=> rdata_valid)
    else $error("read not answered");
  answer_cause_a: assert property (rdata_valid |-> $past(host_req.rd))
    else $error("answer without read");
  unmapped_zero_a: assert property (host_req.rd && !(host_req.addr inside {[8'h5e:8'h61]})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  lock_reserved_a: assert property (rd_at(8'h61) |=> rdata[7:6] == 2'b00)
    else $error("lock reserved bits set");
  fault_reserved_a: assert property (rd_at(8'h60) |=> (rdata & 8'ha4) == 8'h00)
    else $error("fault reserved bits set");
  lock_latch_a: assert property (locks_held ##0 rd_at(8'h61) |=> rdata[5:0] == 6'h3f)
    else $error("lock flags missing");
  mixer_latch_a: assert property (cond.mixer_clip [*5] ##0 rd_at(8'h60) |=> rdata[3])
    else $error("mixer clip missing");
  mask_reserved_a: assert property (rd_at(8'h5e) |=> (rdata & 8'ha4) == 8'h00)
    else $error("mask reserved bits set");
  mic_quiet_a: assert property (cond.global_powerdown [*3] ##0 rd_at(8'h60) |=> !rdata[6])
    else $error("mic short posted without bias");
  reset_quiet_a: assert property (disable iff (1'b0) reset |-> !irq && !rdata_valid)
    else $error("outputs active in reset");
endmodule
bind csif_status_irq csif_status_irq_chk u_chk (.ref_clk, .reset, .host_req, .cond,
  .lock_raw, .rdata, .rdata_valid, .irq);
`default_nettype wire

//--- bench/csif_host_model.sv
// host model making control-port accesses
`timescale 1ns/1ps
`default_nettype none
module csif_host_model (
  input  wire logic          ref_clk,
  output var csif_pkg::csif_req_t host_req,
  input  wire logic [7:0]    rdata,
  input  wire logic          rdata_valid
);
  logic tmo;
  initial
  begin
    host_req = '0;
    tmo = 1'b0;
  end
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    int n;
    @(negedge ref_clk);
    host_req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(negedge ref_clk);
    // released bus shows inverted values so stale ones never match
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    for (n = 0; !w && n < 4 && !rdata_valid; n++)
      @(negedge ref_clk);
    if (!w && !rdata_valid)
      tmo = 1'b1;
    q = rdata;
  endtask
endmodule
`default_nettype wire

//--- bench/tb_csif_status_irq.sv
// self-checking bench for the status and interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tb_csif_status_irq;
  typedef struct packed {
    logic [7:0] m1, m2, cnd;
    logic [5:0] lk;
    logic [7:0] ef, el;
    logic       ei;
  } csif_row_t;
  logic                 ref_clk;
  logic                 reset;
  csif_pkg::csif_req_t  host_req;
  csif_pkg::csif_cond_t cond;
  logic [5:0]           lock_raw;
  logic [7:0]           rdata, q;
  logic                 rdata_valid, irq;
  logic [31:0]          last_lock_cycles;
  int                   fails, total_checks;
  // power-down bits high keep the mic source quiet; its debounce outlasts any row
  csif_row_t rows [9] = '{
    '{8'h01, 8'h00, 8'h43, 6'h00, 8'h01, 8'h00, 1'b1},
    '{8'h00, 8'h00, 8'h83, 6'h00, 8'h02, 8'h00, 1'b0},
    '{8'h08, 8'h00, 8'h23, 6'h00, 8'h08, 8'h00, 1'b1},
    '{8'h10, 8'h00, 8'h1b, 6'h00, 8'h10, 8'h00, 1'b1},
    '{8'h10, 8'h00, 8'h13, 6'h00, 8'h00, 8'h00, 1'b0},
    '{8'h40, 8'h00, 8'h07, 6'h00, 8'h00, 8'h00, 1'b0},
    '{8'h00, 8'h20, 8'h03, 6'h3f, 8'h00, 8'h3f, 1'b1},
    '{8'h00, 8'h0f, 8'h03, 6'h10, 8'h00, 8'h10, 1'b0},
    '{8'h40, 8'h00, 8'h04, 6'h00, 8'h00, 8'h00, 1'b0}
  };
  csif_status_irq dut (.ref_clk, .reset, .host_req, .cond, .lock_raw,
    .rate_programmed(6'h00), .rdata, .rdata_valid, .irq, .last_lock_cycles);
  csif_host_model u_host (.ref_clk, .host_req, .rdata, .rdata_valid);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    u_host.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, e, input string n);
    u_host.access(1'b0, a, 8'h00, q);
    if (u_host.tmo)
    begin
      fails++;
      wrap_up();
    end
    chk(n, e, q);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    reset = 1'b0;
    cond = 8'h03;
    lock_raw = 6'h00;
    fails = 0;
    total_checks = 0;
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    foreach (rows[i])
    begin
      wr(8'h5e, rows[i].m1);
      wr(8'h5f, rows[i].m2);
      cond = rows[i].cnd;
      lock_raw = rows[i].lk;
      repeat (8) @(negedge ref_clk);
      chk("irq", {7'h00, rows[i].ei}, {7'h00, irq});
      rd(8'h60, rows[i].ef, "fault");
      rd(8'h61, rows[i].el, "lock");
      cond = 8'h03;
      lock_raw = 6'h00;
      repeat (6) @(negedge ref_clk);
      rd(8'h60, rows[i].ef, "fault held");
      rd(8'h61, rows[i].el, "lock held");
      rd(8'h60, 8'h00, "fault clear");
      rd(8'h61, 8'h00, "lock clear");
      chk("irq clear", 8'h00, {7'h00, irq});
      $display("row %0d done", i);
    end
    wr(8'h61, 8'hff);
    rd(8'h61, 8'h00, "read-only write");
    rd(8'h10, 8'h00, "unmapped");
    wr(8'h5e, 8'hff);
    rd(8'h5e, 8'h5b, "mask1 used");
    cond = 8'hfb;
    repeat (8) @(negedge ref_clk);
    chk("irq all", 8'h01, {7'h00, irq});
    rd(8'h60, 8'h1b, "fault all");
    reset = 1'b1;
    cond = 8'h03;
    repeat (2) @(negedge ref_clk);
    chk("irq in reset", 8'h00, {7'h00, irq});
    reset = 1'b0;
    cond = 8'hdb;
    repeat (8) @(negedge ref_clk);
    chk("irq masks reset", 8'h00, {7'h00, irq});
    rd(8'h5e, 8'h00, "mask1 reset");
    lock_raw = 6'h3f;
    repeat (6) @(negedge ref_clk);
    lock_raw = 6'h00;
    repeat (10) @(negedge ref_clk);
    lock_raw = 6'h3f;
    repeat (6) @(negedge ref_clk);
    chk("lock time", 8'h0a, last_lock_cycles[7:0]);
    chk("lock time high", 8'h00, {7'h00, |last_lock_cycles[31:8]});
    $display("special cases done");
    wrap_up();
  end
endmodule
`default_nettype wire
